// *** core/ddrax_pkg.sv ***
// Behaviour
// - Two independent target ports: port 0 is 256 bits wide, port 1 is 128.
// - One shared request channel per port; direction low reads, high writes.
// - Controller steps beat addresses using burst kind and beat size.
// - Request valid from master; controller raises request ready when it can accept.
// - Master raises wValid with data; controller raises wReady when it can accept.
// - Controller answers writes with bValid and an 8-bit bId; master gives bReady.
// - Controller returns read data with an 8-bit rId and rLast on last beat.
// - Controller gives a 2-bit read status with every beat and holds rValid.
// - Every port signal is synchronous to that port's own clock.
// - Memory interface supports x16 or x32 data and up to 1066 Mbps per lane; the code fixes DQ_WIDTH at 32 only.
// - A calibration I2C bus reads and writes the configuration registers.
// - The PHY is reachable only through the controller, never directly.
package ddrax_pkg;
    localparam int P0_DATA_W = 256;
    localparam int P1_DATA_W = 128;
    localparam int ADDR_W = 32;
    localparam int TAG_W = 8;
    localparam int LEN_W = 8;
    localparam int SIZE_W = 3;
    localparam int KIND_W = 2;
    localparam int RESP_W = 2;
    localparam int PORT_DEPTH_W = 6;
    localparam logic DIR_READ = 1'h0;
    localparam logic DIR_WRITE = 1'h1;
    localparam logic [1:0] BURST_FIXED = 2'h0;
    localparam logic [1:0] BURST_INCR = 2'h1;
    localparam logic [1:0] BURST_WRAP = 2'h2;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam int DQ_WIDTH = 32;
    localparam int MAX_RATE_MBPS = 1066;
    localparam int MCLK_PERIOD_NS = 20;
    localparam int INIT_TIME_NS = 1000;
    localparam int INIT_CYCLES = (INIT_TIME_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;
    localparam logic [6:0] CAL_DEV_ADDR = 7'h3A;
    localparam int CAL_REG_COUNT = 4;
    localparam logic [7:0] CAL_REG_RESET = 8'h00;
    localparam logic [3:0] I2C_ACK_BIT = 4'h8;
    localparam logic [3:0] I2C_END_BIT = 4'h9;
    typedef enum logic [1:0] {PS_IDLE, PS_WDATA, PS_BRESP, PS_RDATA} ddrax_port_state_t;
    typedef enum logic [1:0] {SQ_IDLE, SQ_RUN, SQ_DONE} ddrax_seq_state_t;
    typedef enum logic [2:0] {I2_IDLE, I2_ADDR, I2_PTR, I2_WR, I2_RD} ddrax_i2c_state_t;
endpackage

// *** core/ddrax_ctrl.sv ***
`timescale 1ns/1ps
module ddrax_port import ddrax_pkg::*; #(
    parameter int DATA_W = P0_DATA_W,
    parameter int DEPTH_W = PORT_DEPTH_W
) (
    input wire logic aclk,
    input wire logic nrst,
    input wire logic initDone,
    input wire logic accessDirection,
    input wire logic [ADDR_W-1:0] sharedRequestAddress,
    input wire logic [TAG_W-1:0] requestTag,
    input wire logic [LEN_W-1:0] burstBeatCount,
    input wire logic [SIZE_W-1:0] beatSize,
    input wire logic [KIND_W-1:0] burstKind,
    input wire logic [1:0] lockKind,
    input wire logic requestValid,
    output logic requestReady,
    input wire logic [DATA_W-1:0] wData,
    input wire logic [DATA_W/8-1:0] wStrb,
    input wire logic [TAG_W-1:0] wId,
    input wire logic wLast,
    input wire logic wValid,
    output logic wReady,
    output logic [TAG_W-1:0] bId,
    output logic bValid,
    input wire logic bReady,
    output logic [DATA_W-1:0] rData,
    output logic [TAG_W-1:0] rId,
    output logic rLast,
    output logic [RESP_W-1:0] rResp,
    output logic rValid,
    input wire logic rReady
);
    localparam int STRB_W = DATA_W / 8;
    localparam int LSB = $clog2(STRB_W);

    logic [DATA_W-1:0] mem [0:(1<<DEPTH_W)-1];
    logic rstMeta_reg, rstN_reg, initMeta_reg, init_reg;
    ddrax_port_state_t state_reg;
    logic [ADDR_W-1:0] addr_reg, addrNext;
    logic [TAG_W-1:0] tag_reg;
    logic [LEN_W-1:0] len_reg, beat_reg;
    logic [SIZE_W-1:0] size_reg;
    logic [KIND_W-1:0] kind_reg;
    logic [DATA_W-1:0] rData_reg;
    logic rLast_reg, rValid_reg;
    logic [RESP_W-1:0] rResp_reg;
    logic reqFire, wFire, rFire;

    function automatic logic [ADDR_W-1:0] nextBeatAddr(input logic [ADDR_W-1:0] a,
        input logic [SIZE_W-1:0] sz, input logic [KIND_W-1:0] k, input logic [LEN_W-1:0] n);
        logic [ADDR_W-1:0] step, mask;
        step = ADDR_W'(1) << sz;
        mask = ((ADDR_W'(n) + ADDR_W'(1)) << sz) - ADDR_W'(1);
        case (k)
            BURST_FIXED: nextBeatAddr = a;
            BURST_WRAP: nextBeatAddr = (a & ~mask) | ((a + step) & mask);
            default: nextBeatAddr = a + step;
        endcase
    endfunction

    function automatic logic inWindow(input logic [ADDR_W-1:0] a);
        inWindow = (a >> (LSB + DEPTH_W)) == '0;
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // reset and init-done crossings into this port's clock
    always_ff @(posedge aclk) begin
        rstMeta_reg <= nrst;
        rstN_reg <= rstMeta_reg;
    end

    always_ff @(posedge aclk) begin
        if (!rstN_reg) begin
            initMeta_reg <= 1'h0;
            init_reg <= 1'h0;
        end else begin
            initMeta_reg <= initDone;
            init_reg <= initMeta_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // handshakes
    assign requestReady = (state_reg == PS_IDLE) && init_reg;
    assign reqFire = requestValid && requestReady;
    assign wReady = state_reg == PS_WDATA;
    assign wFire = wValid && wReady;
    assign bValid = state_reg == PS_BRESP;
    assign bId = tag_reg;
    assign rFire = rValid_reg && rReady;
    assign rData = rData_reg;
    assign rId = tag_reg;
    assign rLast = rLast_reg;
    assign rResp = rResp_reg;
    assign rValid = rValid_reg;

    always_ff @(posedge aclk) begin
        if (!rstN_reg) begin
            state_reg <= PS_IDLE;
        end else begin
            case (state_reg)
                PS_IDLE: if (reqFire) begin
                    state_reg <= (accessDirection == DIR_WRITE) ? PS_WDATA : PS_RDATA;
                end
                PS_WDATA: if (wFire && wLast) begin
                    state_reg <= PS_BRESP;
                end
                PS_BRESP: if (bReady) begin
                    state_reg <= PS_IDLE;
                end
                PS_RDATA: if (rFire && rLast_reg) begin
                    state_reg <= PS_IDLE;
                end
                default: state_reg <= PS_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // request capture and beat address stepping
    assign addrNext = reqFire ? sharedRequestAddress
                              : nextBeatAddr(addr_reg, size_reg, kind_reg, len_reg);

    always_ff @(posedge aclk) begin
        if (!rstN_reg) begin
            addr_reg <= '0;
            tag_reg <= '0;
            len_reg <= '0;
            size_reg <= '0;
            kind_reg <= BURST_INCR;
            beat_reg <= '0;
        end else if (reqFire) begin
            addr_reg <= sharedRequestAddress;
            tag_reg <= requestTag;
            len_reg <= burstBeatCount;
            size_reg <= beatSize;
            kind_reg <= burstKind;
            beat_reg <= '0;
        end else if (wFire || rFire) begin
            addr_reg <= addrNext;
            beat_reg <= beat_reg + LEN_W'(1);
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // storage: byte lanes written under strobe, out-of-window beats dropped
    always_ff @(posedge aclk) begin
        if (wFire && inWindow(addr_reg)) begin
            for (int i = 0; i < STRB_W; i++) begin
                if (wStrb[i]) begin
                    mem[addr_reg[LSB +: DEPTH_W]][i*8 +: 8] <= wData[i*8 +: 8];
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // read data channel, registered and held until taken
    always_ff @(posedge aclk) begin
        if (!rstN_reg) begin
            rValid_reg <= 1'h0;
            rLast_reg <= 1'h0;
            rResp_reg <= RESP_OKAY;
            rData_reg <= '0;
        end else if ((reqFire && accessDirection == DIR_READ) || (rFire && !rLast_reg)) begin
            rValid_reg <= 1'h1;
            rData_reg <= mem[addrNext[LSB +: DEPTH_W]];
            rLast_reg <= reqFire ? (burstBeatCount == '0) : (beat_reg + LEN_W'(1) == len_reg);
            rResp_reg <= inWindow(addrNext) ? RESP_OKAY : RESP_SLVERR;
        end else if (rFire) begin
            rValid_reg <= 1'h0;
            rLast_reg <= 1'h0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!rstN_reg);

    sequence wrReqSeq;
        reqFire && accessDirection == DIR_WRITE;
    endsequence

    sequence wrLastSeq;
        wFire && wLast;
    endsequence

    write_opens_a: assert property (wrReqSeq |=> wReady && !requestReady)
        else $error("write request did not open write data");
    read_tag_a: assert property (reqFire && accessDirection == DIR_READ
        |=> rValid && rId == $past(requestTag))
        else $error("read data missing or wrong tag");
    single_last_a: assert property (reqFire && !accessDirection && burstBeatCount == '0
        |=> rLast)
        else $error("single beat read lacks last");
    rdata_hold_a: assert property (rValid && !rReady
        |=> rValid && $stable(rData) && $stable(rLast) && $stable(rResp))
        else $error("read beat changed before taken");
    bresp_after_a: assert property ($rose(bValid) |-> $past(wFire && wLast))
        else $error("write response without last beat");
    bresp_follows_a: assert property (wrLastSeq |=> bValid && !wReady)
        else $error("write response not raised after last beat");
    bresp_hold_a: assert property (bValid && !bReady |=> bValid && $stable(bId))
        else $error("write response dropped before taken");
    incr_step_a: assert property (rFire && !rLast && kind_reg == BURST_INCR
        |=> addr_reg == $past(addr_reg) + (ADDR_W'(1) << $past(size_reg)))
        else $error("increment burst stepped wrongly");
    fixed_step_a: assert property ((wFire || rFire) && kind_reg == BURST_FIXED
        |=> $stable(addr_reg))
        else $error("fixed burst address moved");
    ready_gate_a: assert property (!init_reg |-> !requestReady)
        else $error("request taken before init done");
    resp_code_a: assert property (rValid |-> rResp == RESP_OKAY || rResp == RESP_SLVERR)
        else $error("bad read status");
endmodule // ddrax_port

module ddrax_ctrl import ddrax_pkg::*; #(
    parameter int DEPTH_W = PORT_DEPTH_W
) (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic sequencerGo,
    input wire logic sequencerReset,
    output logic interfaceReady,
    input wire logic calScl,
    input wire logic calSdaIn,
    output logic calSdaOut,
    output logic calSdaOe,
    output logic [CAL_REG_COUNT*8-1:0] phyTrim,
    input wire logic aclk0,
    input wire logic accessDirection0,
    input wire logic [ADDR_W-1:0] sharedRequestAddress0,
    input wire logic [TAG_W-1:0] requestTag0,
    input wire logic [LEN_W-1:0] burstBeatCount0,
    input wire logic [SIZE_W-1:0] beatSize0,
    input wire logic [KIND_W-1:0] burstKind0,
    input wire logic [1:0] lockKind0,
    input wire logic requestValid0,
    output logic requestReady0,
    input wire logic [P0_DATA_W-1:0] wData0,
    input wire logic [P0_DATA_W/8-1:0] wStrb0,
    input wire logic [TAG_W-1:0] wId0,
    input wire logic wLast0,
    input wire logic wValid0,
    output logic wReady0,
    output logic [TAG_W-1:0] bId0,
    output logic bValid0,
    input wire logic bReady0,
    output logic [P0_DATA_W-1:0] rData0,
    output logic [TAG_W-1:0] rId0,
    output logic rLast0,
    output logic [RESP_W-1:0] rResp0,
    output logic rValid0,
    input wire logic rReady0,
    input wire logic aclk1,
    input wire logic accessDirection1,
    input wire logic [ADDR_W-1:0] sharedRequestAddress1,
    input wire logic [TAG_W-1:0] requestTag1,
    input wire logic [LEN_W-1:0] burstBeatCount1,
    input wire logic [SIZE_W-1:0] beatSize1,
    input wire logic [KIND_W-1:0] burstKind1,
    input wire logic [1:0] lockKind1,
    input wire logic requestValid1,
    output logic requestReady1,
    input wire logic [P1_DATA_W-1:0] wData1,
    input wire logic [P1_DATA_W/8-1:0] wStrb1,
    input wire logic [TAG_W-1:0] wId1,
    input wire logic wLast1,
    input wire logic wValid1,
    output logic wReady1,
    output logic [TAG_W-1:0] bId1,
    output logic bValid1,
    input wire logic bReady1,
    output logic [P1_DATA_W-1:0] rData1,
    output logic [TAG_W-1:0] rId1,
    output logic rLast1,
    output logic [RESP_W-1:0] rResp1,
    output logic rValid1,
    input wire logic rReady1
);
    logic goMeta_reg, goSync_reg, goPrev_reg, srMeta_reg, srSync_reg;
    ddrax_seq_state_t seq_reg;
    logic [$clog2(INIT_CYCLES+1)-1:0] initCnt_reg;
    logic sclMeta_reg, scl_reg, sclPrev_reg, sdaMeta_reg, sda_reg, sdaPrev_reg;
    ddrax_i2c_state_t i2_reg;
    logic [3:0] bitCnt_reg;
    logic [7:0] shift_reg;
    logic [1:0] ptr_reg;
    logic isRead_reg, sdaOe_reg;
    logic [7:0] cfg_reg [0:CAL_REG_COUNT-1];
    logic sclRise, sclFall, startCond, stopCond;

    ////////////////////////////////////////////////////////////////////////////////
    // startup sequencer: the ports refuse requests until it has finished
    always_ff @(posedge mclk) begin
        goMeta_reg <= sequencerGo;
        goSync_reg <= goMeta_reg;
        goPrev_reg <= goSync_reg;
        srMeta_reg <= sequencerReset;
        srSync_reg <= srMeta_reg;
    end

    always_ff @(posedge mclk) begin
        if (!nrst || srSync_reg) begin
            seq_reg <= SQ_IDLE;
            initCnt_reg <= '0;
        end else begin
            case (seq_reg)
                SQ_IDLE: if (goSync_reg && !goPrev_reg) begin
                    seq_reg <= SQ_RUN;
                end
                SQ_RUN: if (initCnt_reg == ($bits(initCnt_reg))'(INIT_CYCLES - 1)) begin
                    seq_reg <= SQ_DONE;
                end else begin
                    initCnt_reg <= initCnt_reg + 1'h1;
                end
                SQ_DONE: seq_reg <= SQ_DONE;
                default: seq_reg <= SQ_IDLE;
            endcase
        end
    end

    assign interfaceReady = seq_reg == SQ_DONE;

    ////////////////////////////////////////////////////////////////////////////////
    // calibration I2C target: pointer byte, then data bytes with auto increment
    always_ff @(posedge mclk) begin
        sclMeta_reg <= calScl;
        scl_reg <= sclMeta_reg;
        sclPrev_reg <= scl_reg;
        sdaMeta_reg <= calSdaIn;
        sda_reg <= sdaMeta_reg;
        sdaPrev_reg <= sda_reg;
    end

    assign sclRise = scl_reg && !sclPrev_reg;
    assign sclFall = !scl_reg && sclPrev_reg;
    assign startCond = scl_reg && sclPrev_reg && sdaPrev_reg && !sda_reg;
    assign stopCond = scl_reg && sclPrev_reg && !sdaPrev_reg && sda_reg;

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            i2_reg <= I2_IDLE;
            bitCnt_reg <= '0;
            shift_reg <= '0;
            ptr_reg <= '0;
            isRead_reg <= 1'h0;
            sdaOe_reg <= 1'h0;
            for (int i = 0; i < CAL_REG_COUNT; i++) begin
                cfg_reg[i] <= CAL_REG_RESET;
            end
        end else if (startCond) begin
            i2_reg <= I2_ADDR;
            bitCnt_reg <= '0;
            sdaOe_reg <= 1'h0;
        end else if (stopCond) begin
            i2_reg <= I2_IDLE;
            sdaOe_reg <= 1'h0;
        end else if (i2_reg != I2_IDLE && sclRise) begin
            bitCnt_reg <= bitCnt_reg + 4'h1;
            if (i2_reg != I2_RD && bitCnt_reg < I2C_ACK_BIT) begin
                shift_reg <= {shift_reg[6:0], sda_reg};
            end
            if (i2_reg == I2_RD && bitCnt_reg == I2C_ACK_BIT && sda_reg) begin
                i2_reg <= I2_IDLE;
            end
        end else if (i2_reg != I2_IDLE && sclFall) begin
            if (bitCnt_reg == I2C_ACK_BIT) begin
                sdaOe_reg <= i2_reg != I2_RD;
                case (i2_reg)
                    I2_ADDR: begin
                        isRead_reg <= shift_reg[0];
                        if (shift_reg[7:1] != CAL_DEV_ADDR) begin
                            i2_reg <= I2_IDLE;
                            sdaOe_reg <= 1'h0;
                        end
                    end
                    I2_PTR: ptr_reg <= shift_reg[1:0];
                    I2_WR: begin
                        cfg_reg[ptr_reg] <= shift_reg;
                        ptr_reg <= ptr_reg + 2'h1;
                    end
                    default: sdaOe_reg <= 1'h0;
                endcase
            end else if (bitCnt_reg == I2C_END_BIT) begin
                bitCnt_reg <= '0;
                sdaOe_reg <= 1'h0;
                if ((i2_reg == I2_ADDR && isRead_reg) || i2_reg == I2_RD) begin
                    i2_reg <= I2_RD;
                    shift_reg <= cfg_reg[ptr_reg];
                    ptr_reg <= ptr_reg + 2'h1;
                    sdaOe_reg <= !cfg_reg[ptr_reg][7];
                end else if (i2_reg == I2_ADDR) begin
                    i2_reg <= I2_PTR;
                end else begin
                    i2_reg <= I2_WR;
                end
            end else if (i2_reg == I2_RD) begin
                sdaOe_reg <= !shift_reg[3'h7 - bitCnt_reg[2:0]];
            end
        end
    end

    assign calSdaOut = 1'h0;
    assign calSdaOe = sdaOe_reg;
    // the trim bytes are the only path toward the PHY; the fabric cannot reach it otherwise
    always_comb begin
        for (int i = 0; i < CAL_REG_COUNT; i++) begin
            phyTrim[i*8 +: 8] = cfg_reg[i];
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // the two fabric ports, each in its own clock domain
    ddrax_port #(.DATA_W(P0_DATA_W), .DEPTH_W(DEPTH_W)) port0 (
        .aclk(aclk0), .nrst(nrst), .initDone(interfaceReady),
        .accessDirection(accessDirection0), .sharedRequestAddress(sharedRequestAddress0),
        .requestTag(requestTag0), .burstBeatCount(burstBeatCount0), .beatSize(beatSize0),
        .burstKind(burstKind0), .lockKind(lockKind0), .requestValid(requestValid0),
        .requestReady(requestReady0), .wData(wData0), .wStrb(wStrb0), .wId(wId0),
        .wLast(wLast0), .wValid(wValid0), .wReady(wReady0), .bId(bId0), .bValid(bValid0),
        .bReady(bReady0), .rData(rData0), .rId(rId0), .rLast(rLast0), .rResp(rResp0),
        .rValid(rValid0), .rReady(rReady0)
    );

    ddrax_port #(.DATA_W(P1_DATA_W), .DEPTH_W(DEPTH_W)) port1 (
        .aclk(aclk1), .nrst(nrst), .initDone(interfaceReady),
        .accessDirection(accessDirection1), .sharedRequestAddress(sharedRequestAddress1),
        .requestTag(requestTag1), .burstBeatCount(burstBeatCount1), .beatSize(beatSize1),
        .burstKind(burstKind1), .lockKind(lockKind1), .requestValid(requestValid1),
        .requestReady(requestReady1), .wData(wData1), .wStrb(wStrb1), .wId(wId1),
        .wLast(wLast1), .wValid(wValid1), .wReady(wReady1), .bId(bId1), .bValid(bValid1),
        .bReady(bReady1), .rData(rData1), .rId(rId1), .rLast(rLast1), .rResp(rResp1),
        .rValid(rValid1), .rReady(rReady1)
    );
endmodule // ddrax_ctrl

// *** verification/ddrax_master.sv ***
`timescale 1ns/1ps
module ddrax_master import ddrax_pkg::*; #(
    parameter int DW = P1_DATA_W,
    parameter logic [KIND_W-1:0] KIND = BURST_INCR
) (
    input wire logic c, input wire logic go, output logic done, output logic [3:0] ok,
    output logic d, output logic [ADDR_W-1:0] a, output logic [TAG_W-1:0] t,
    output logic [LEN_W-1:0] n, output logic [SIZE_W-1:0] sz, output logic [KIND_W-1:0] k,
    output logic [1:0] lk, output logic av, input wire logic ar, output logic [DW-1:0] wd,
    output logic [DW/8-1:0] ws, output logic [TAG_W-1:0] wi, output logic wl,
    output logic wv, input wire logic wr, input wire logic [TAG_W-1:0] bi,
    input wire logic bv, output logic br, input wire logic [DW-1:0] rd,
    input wire logic [TAG_W-1:0] ri, input wire logic rl, input wire logic [RESP_W-1:0] rs,
    input wire logic rv, output logic rr
);
    localparam logic [DW-1:0] PAT = {(DW / 32){32'hC0DE1234}};
    task automatic req(input logic dir);
        d = dir;
        a = 32'h00000040;
        t = dir ? 8'hA5 : 8'h3C;
        n = 8'h01;
        {sz, k} = {SIZE_W'($clog2(DW / 8)), KIND};
        lk = 2'h0;
        av = 1'h1;
        do @(posedge c); while (ar !== 1'h1);
        #1 {av, a} = {1'h0, ~a};
    endtask
    initial begin
        {done, d, av, wv, wl, br, rr, a, t, n, sz, k, lk, wd, ws, wi} = '0;
        ok = 4'hF;
        @(posedge go);
        @(posedge c);
        #1 req(DIR_WRITE);
        for (int i = 0; i < 2; i++) begin
            wd = i ? ~PAT : PAT;
            {wi, ws} = {t, {(DW / 8){1'h1}}};
            {wv, wl} = {1'h1, i == 1};
            do @(posedge c); while (wr !== 1'h1);
            #1;
        end
        {wv, wl, wd} = {2'h0, ~wd};
        br = 1'h1;
        do @(posedge c); while (bv !== 1'h1);
        ok[0] = (bi === 8'hA5);
        #1 br = 1'h0;
        req(DIR_READ);
        // read data must stand while not yet taken
        repeat (3) @(posedge c);
        #1 rr = 1'h1;
        for (int i = 0; i < 2; i++) begin
            do @(posedge c); while (rv !== 1'h1);
            // a fixed burst rewrites one word, so both beats read back the last one written
            ok[1] = ok[1] && (rd === ((i || KIND == BURST_FIXED) ? ~PAT : PAT));
            ok[2] = ok[2] && (rl === (i == 1)) && (rs === RESP_OKAY);
            ok[3] = ok[3] && (ri === 8'h3C);
        end
        #1 rr = 1'h0;
        done = 1'h1;
    end
endmodule // ddrax_master

// *** verification/ddrax_ctrl_tb.sv ***
`timescale 1ns/1ps
module ddrax_ctrl_tb import ddrax_pkg::*;;
    logic mclk = 1'h0, aclk1 = 1'h0, nrst = 1'h0, sequencerGo = 1'h0, go = 1'h0;
    logic sequencerReset = 1'h0, done0, done1, interfaceReady, calSdaOut, calSdaOe;
    logic accessDirection0, requestValid0, requestReady0, wLast0, wValid0, wReady0, bValid0;
    logic bReady0, rLast0, rValid0, rReady0, accessDirection1, requestValid1, requestReady1;
    logic wLast1, wValid1, wReady1, bValid1, bReady1, rLast1, rValid1, rReady1;
    logic [1:0] lockKind0, burstKind0, rResp0, lockKind1, burstKind1, rResp1;
    logic [2:0] beatSize0, beatSize1;
    logic [3:0] ok0, ok1;
    logic [7:0] requestTag0, burstBeatCount0, wId0, bId0, rId0;
    logic [7:0] requestTag1, burstBeatCount1, wId1, bId1, rId1;
    logic [15:0] wStrb1;
    logic [31:0] sharedRequestAddress0, sharedRequestAddress1, phyTrim, wStrb0;
    logic [127:0] wData1, rData1;
    logic [255:0] wData0, rData0;
    logic calScl = 1'h1, sdaDrv = 1'h1;
    wire logic aclk0 = mclk;
    // open-drain line: pulled up unless either side pulls it low
    wire logic calSdaIn = sdaDrv && !calSdaOe;
    int n_fail = 0, compares = 0, cycles = 0;
    ddrax_ctrl i_ddrax_ctrl (.*);
    ddrax_master #(.DW(P0_DATA_W)) i_ddrax_master0 (.c(aclk0), .go(go), .done(done0), .ok(ok0),
        .d(accessDirection0), .a(sharedRequestAddress0), .t(requestTag0), .n(burstBeatCount0),
        .sz(beatSize0), .k(burstKind0), .lk(lockKind0), .av(requestValid0), .ar(requestReady0),
        .wd(wData0), .ws(wStrb0), .wi(wId0), .wl(wLast0), .wv(wValid0), .wr(wReady0),
        .bi(bId0), .bv(bValid0), .br(bReady0), .rd(rData0), .ri(rId0), .rl(rLast0),
        .rs(rResp0), .rv(rValid0), .rr(rReady0));
    ddrax_master #(.DW(P1_DATA_W), .KIND(BURST_FIXED)) i_ddrax_master1 (.c(aclk1), .go(go),
        .done(done1), .ok(ok1),
        .d(accessDirection1), .a(sharedRequestAddress1), .t(requestTag1), .n(burstBeatCount1),
        .sz(beatSize1), .k(burstKind1), .lk(lockKind1), .av(requestValid1), .ar(requestReady1),
        .wd(wData1), .ws(wStrb1), .wi(wId1), .wl(wLast1), .wv(wValid1), .wr(wReady1),
        .bi(bId1), .bv(bValid1), .br(bReady1), .rd(rData1), .ri(rId1), .rl(rLast1),
        .rs(rResp1), .rv(rValid1), .rr(rReady1));
    task automatic chk(input string what, input logic [7:0] exp, got);
        compares++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic final_report();
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task automatic test_init();
        chk("requestReady0", 8'h00, 8'(requestReady0));
        sequencerGo = 1'h1;
        repeat (4) @(posedge mclk);
        #1 sequencerGo = 1'h0;
        for (int i = 0; i < 200 && interfaceReady !== 1'h1; i++) @(posedge mclk);
        chk("interfaceReady", 8'h01, 8'(interfaceReady));
    endtask
    task automatic test_ports();
        #1 go = 1'h1;
        for (int i = 0; i < 3000 && (done0 & done1) !== 1'h1; i++) @(posedge mclk);
        chk("port0 results", 8'h0F, 8'(ok0));
        chk("port1 results", 8'h0F, 8'(ok1));
        chk("ports done", 8'h01, 8'(done0 & done1));
    endtask
    task automatic cal_bit(input logic b);
        sdaDrv = b;
        repeat (6) @(posedge mclk);
        #1 calScl = 1'h1;
        repeat (6) @(posedge mclk);
        #1 calScl = 1'h0;
    endtask
    task automatic cal_byte(input logic [7:0] v);
        for (int i = 7; i >= 0; i--) cal_bit(v[i]);
        sdaDrv = 1'h1;
        repeat (6) @(posedge mclk);
        #1 calScl = 1'h1;
        repeat (6) @(posedge mclk);
        #1 chk("cal ack", 8'h01, 8'(!calSdaIn));
        calScl = 1'h0;
    endtask
    task automatic test_cal();
        // start: data falls while the clock line is high
        #1 sdaDrv = 1'h0;
        repeat (6) @(posedge mclk);
        #1 calScl = 1'h0;
        cal_byte({CAL_DEV_ADDR, 1'h0});
        cal_byte(8'h01);
        cal_byte(8'h5A);
        sdaDrv = 1'h0;
        repeat (6) @(posedge mclk);
        #1 calScl = 1'h1;
        repeat (6) @(posedge mclk);
        #1 sdaDrv = 1'h1;
        repeat (6) @(posedge mclk);
        #1 chk("trim byte 1", 8'h5A, phyTrim[15:8]);
        chk("trim byte 0", CAL_REG_RESET, phyTrim[7:0]);
        chk("cal release", 8'h00, 8'(calSdaOe));
    endtask
    initial forever #10 mclk = ~mclk;
    initial #7 forever #24 aclk1 = ~aclk1;
    always @(posedge mclk) if (++cycles == 20000) begin
        n_fail++;
        final_report();
    end
    initial begin
        repeat (8) @(posedge mclk);
        #1 nrst = 1'h1;
        test_init();
        test_cal();
        test_ports();
        final_report();
    end
endmodule // ddrax_ctrl_tb
